// File: pkg/sto_pkg.sv
`default_nettype none
package sto_pkg;

  // Clock rate in kHz.
  localparam int unsigned CLK_KHZ = 50000;

  // Times in their printed units.
  localparam int unsigned MISMATCH_S    = 10;
  localparam int unsigned OFF_LATENCY_US = 4000;
  localparam int unsigned GLITCH_US     = 500;

  // A glitch of GLITCH_US or less must be ignored; the filter accepts an OFF
  // level only once it has lasted strictly longer than that.
  localparam int unsigned GLITCH_CYC = GLITCH_US * (CLK_KHZ / 1000);
  localparam int unsigned FILTER_CYC = GLITCH_CYC + 1;

  // Longest allowed delay from both channels OFF to power removal.
  localparam int unsigned OFF_LATENCY_CYC = OFF_LATENCY_US * (CLK_KHZ / 1000);

  // Mismatch terminal count; 64-bit product, though it stays below 2^31.
  localparam longint unsigned MISMATCH_CYC =
    64'(MISMATCH_S) * 64'(CLK_KHZ) * 64'd1000;

  // Drive state machine.
  typedef enum logic [1:0] {
    ST_SAFE_OFF  = 2'b00,
    ST_BASE_BLK  = 2'b01,
    ST_RUN       = 2'b10,
    ST_WAIT_SVOFF = 2'b11
  } drive_state_e;

  // Filtered channel levels, high means ON (current flowing).
  typedef struct packed {
    logic chan_a_on;
    logic chan_b_on;
  } chan_level_s;

  // Status outputs grouped together.
  typedef struct packed {
    logic gate_enable;
    logic servo_ready;
    logic safe_off;
    logic base_block;
    logic timing_alarm;
  } drive_status_s;

endpackage
`default_nettype wire

// File: design/sto_input_filter.sv
`default_nettype none
// Synchronises one safety input and rejects short OFF pulses. An ON level is
// passed at once so that recovery is not delayed; only the fall to OFF is
// qualified. Reset state is OFF, so the drive starts in safe-off.
module sto_input_filter #(
  parameter int unsigned FILTER_CYC = sto_pkg::FILTER_CYC
) (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic raw_on_i,
  output logic      on_o
);

  localparam int unsigned CW = $clog2(FILTER_CYC + 1);

  logic          sync1_q;
  logic          sync2_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          on_q;
  logic          on_d;

  // Filter: count consecutive OFF samples, drop ON only after FILTER_CYC.
  always_comb
  begin
    cnt_d = cnt_q;
    on_d  = on_q;
    if (sync2_q)
    begin
      cnt_d = '0;
      on_d  = 1'b1;
    end
    else if (cnt_q >= CW'(FILTER_CYC - 1))
    begin
      on_d = 1'b0; // see [RQ9]
    end
    else
    begin
      cnt_d = cnt_q + CW'(1);
    end
  end

  // Two-stage synchroniser, then the filter registers.
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      cnt_q   <= '0;
      on_q    <= 1'b0;
    end
    else
    begin
      sync1_q <= raw_on_i;
      sync2_q <= sync1_q;
      cnt_q   <= cnt_d;
      on_q    <= on_d;
    end
  end

  assign on_o = on_q;

endmodule
`default_nettype wire

// File: design/safe_torque_off.sv
`default_nettype none
// Contract
// [RQ1] Either safety input OFF enters safe-off and stops motor current.
// [RQ2] Each channel alone forces the power stage gate drive off.
// [RQ3] From safe-off, both inputs ON moves to base-block, ready for servo-on.
// [RQ4] Safe-off under servo-on needs servo-on dropped then reasserted.
// [RQ5] Controller should drop servo-on before turning both inputs OFF.
// [RQ6] Channels disagreeing for 10 s raise the timing alarm.
// [RQ7] Input is ON only with current flowing; open or grounded reads OFF.
// [RQ8] Both channels OFF removes motor power within 4 ms.
// [RQ9] OFF pulses of 0.5 ms or less are ignored.
// [RQ10] In safe-off, servo-on is ignored and servo ready is held OFF.
// [RQ11] Mismatch timer starts on disagreement, clears on agreement, alarms.
module safe_torque_off #(
  parameter longint unsigned MISMATCH_CYC = sto_pkg::MISMATCH_CYC,
  parameter int unsigned     FILTER_CYC   = sto_pkg::FILTER_CYC
) (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic safety_off_request_a_i,
  input  wire logic safety_off_request_b_i,
  input  wire logic servo_on_i,
  input  wire logic alarm_clear_i,
  output logic      gate_enable_a_o,
  output logic      gate_enable_b_o,
  output logic      servo_ready_o,
  output logic      hardwired_safe_off_state_o,
  output logic      base_block_state_o,
  output logic      safety_input_timing_alarm_o
);

  // Width of the mismatch counter. At the default count this is a 29-bit
  // counter; it saturates at the terminal count, so a channel that stays
  // stuck for hours never wraps and loses the alarm condition.
  localparam int unsigned MW = $clog2(MISMATCH_CYC + 1);

  // Filtered channel levels and the synchronised host inputs. The host
  // inputs come from another board, so they pass two flip-flops first.
  sto_pkg::chan_level_s   chan;
  logic                   svon_s1_q;
  logic                   svon_q;
  logic                   clr_s1_q;
  logic                   clr_q;

  // Drive state, registered status, gate enables and the supervisor.
  sto_pkg::drive_state_e  state_q;
  sto_pkg::drive_state_e  state_d;
  sto_pkg::drive_status_s stat_q;
  sto_pkg::drive_status_s stat_d;
  logic                   gate_a_q;
  logic                   gate_a_d;
  logic                   gate_b_q;
  logic                   gate_b_d;
  logic [MW-1:0]          mis_q;
  logic [MW-1:0]          mis_d;
  logic                   alarm_q;
  logic                   alarm_d;

  // A safety input high means current flows into the pin. An open or
  // grounded line reads low and therefore as OFF. see [RQ7]
  sto_input_filter #(
    .FILTER_CYC (FILTER_CYC)
  ) u_filt_a (
    .clk_i    (clk_i),
    .nrst_i   (nrst_i),
    .raw_on_i (safety_off_request_a_i),
    .on_o     (chan.chan_a_on)
  );

  // Channel B has its own filter, so one stuck filter cannot mask the other.
  sto_input_filter #(
    .FILTER_CYC (FILTER_CYC)
  ) u_filt_b (
    .clk_i    (clk_i),
    .nrst_i   (nrst_i),
    .raw_on_i (safety_off_request_b_i),
    .on_o     (chan.chan_b_on)
  );

  // Drive state machine and status outputs. The states are:
  //   safe-off        power stage off, servo-on ignored, ready held off;
  //   wait-servo-off  both channels back while servo-on is still up, so
  //                   the host must drop it once before the drive re-arms;
  //   base-block      both channels ON and ready for servo-on;
  //   run             gates driven.
  // Status is decoded from the next state, timing_alarm from alarm_d, so that
  // every status register changes on the same edge as the register it reports.
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      sto_pkg::ST_SAFE_OFF:
      begin
        // Servo-on is ignored here; leaving needs both channels ON.
        // Servo-on still up on return means it was never dropped.
        if (chan.chan_a_on && chan.chan_b_on)
        begin
          if (svon_q)
            state_d = sto_pkg::ST_WAIT_SVOFF; // see [RQ4]
          else
            state_d = sto_pkg::ST_BASE_BLK; // see [RQ3]
        end
      end
      sto_pkg::ST_WAIT_SVOFF:
      begin
        // A channel lost again drops back to plain safe-off.
        if (!(chan.chan_a_on && chan.chan_b_on))
          state_d = sto_pkg::ST_SAFE_OFF;
        else if (!svon_q)
          state_d = sto_pkg::ST_BASE_BLK; // see [RQ4]
      end
      sto_pkg::ST_BASE_BLK:
      begin
        // Ready and waiting; a raised servo-on starts the run only from here.
        if (!(chan.chan_a_on && chan.chan_b_on))
          state_d = sto_pkg::ST_SAFE_OFF; // see [RQ1]
        else if (svon_q)
          state_d = sto_pkg::ST_RUN;
      end
      sto_pkg::ST_RUN:
      begin
        // Losing either channel stops the gates before anything else.
        if (!(chan.chan_a_on && chan.chan_b_on))
          state_d = sto_pkg::ST_SAFE_OFF; // see [RQ1]
        else if (!svon_q)
          state_d = sto_pkg::ST_BASE_BLK;
      end
      default:
      begin
        state_d = sto_pkg::ST_SAFE_OFF;
      end
    endcase

    stat_d.safe_off     = (state_d == sto_pkg::ST_SAFE_OFF) ||
                          (state_d == sto_pkg::ST_WAIT_SVOFF);
    stat_d.base_block   = (state_d == sto_pkg::ST_BASE_BLK);
    // Ready only in base-block, never while safe-off holds. see [RQ10]
    stat_d.servo_ready  = (state_d == sto_pkg::ST_BASE_BLK);
    stat_d.gate_enable  = (state_d == sto_pkg::ST_RUN);
    stat_d.timing_alarm = alarm_d;
  end

  // Each gate enable is also qualified directly by its own channel, so a
  // stuck state machine or the other channel's path cannot keep it on.
  // Removal follows the filter output by one cycle; with synchroniser and
  // filter the total stays far inside the 4 ms budget. Registering both
  // enables costs that cycle but keeps the power stage free of glitches.
  always_comb
  begin
    gate_a_d = stat_d.gate_enable && chan.chan_a_on; // see [RQ2] [RQ8]
    gate_b_d = stat_d.gate_enable && chan.chan_b_on; // see [RQ2] [RQ8]
  end

  // Mismatch supervisor. The alarm is sticky until a clear request, but a
  // terminal count in the same cycle wins over the clear, so a clear held
  // during a lasting mismatch has no effect. The alarm only reports: it
  // never touches the state machine, which already shuts down on any OFF.
  always_comb
  begin
    mis_d   = mis_q;
    alarm_d = alarm_q;
    if (chan.chan_a_on == chan.chan_b_on)
    begin
      mis_d = '0; // see [RQ11]
    end
    else if (mis_q < MW'(MISMATCH_CYC))
    begin
      mis_d = mis_q + MW'(1); // see [RQ11]
    end
    if (clr_q)
      alarm_d = 1'b0;
    if (chan.chan_a_on != chan.chan_b_on &&
        mis_q >= MW'(MISMATCH_CYC - 1))
      alarm_d = 1'b1; // see [RQ6] [RQ11]
  end

  // Register all state; host inputs are synchronised first. Every reset
  // value is the safe one, so the drive never moves before both channels
  // have been seen ON.
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      svon_s1_q <= 1'b0;
      svon_q    <= 1'b0;
      clr_s1_q  <= 1'b0;
      clr_q     <= 1'b0;
      state_q   <= sto_pkg::ST_SAFE_OFF;
      stat_q    <= '{gate_enable  : 1'b0,
                     servo_ready  : 1'b0,
                     safe_off     : 1'b1,
                     base_block   : 1'b0,
                     timing_alarm : 1'b0}; // see [RQ1]
      gate_a_q  <= 1'b0;
      gate_b_q  <= 1'b0;
      mis_q     <= '0;
      alarm_q   <= 1'b0;
    end
    else
    begin
      svon_s1_q <= servo_on_i;
      svon_q    <= svon_s1_q;
      clr_s1_q  <= alarm_clear_i;
      clr_q     <= clr_s1_q;
      state_q   <= state_d;
      stat_q    <= stat_d;
      gate_a_q  <= gate_a_d;
      gate_b_q  <= gate_b_d;
      mis_q     <= mis_d;
      alarm_q   <= alarm_d;
    end
  end

  // Outputs come straight from registers, so no decode glitch reaches
  // the power stage or the host.
  assign gate_enable_a_o             = gate_a_q;
  assign gate_enable_b_o             = gate_b_q;
  assign servo_ready_o               = stat_q.servo_ready;
  assign hardwired_safe_off_state_o  = stat_q.safe_off;
  assign base_block_state_o          = stat_q.base_block;
  assign safety_input_timing_alarm_o = stat_q.timing_alarm;

endmodule
`default_nettype wire

// File: sim/safe_torque_off_asserts.sv
`default_nettype none
// Judges the drive ports against raw input history.
module sto_checker #(
  parameter longint unsigned MISMATCH_CYC = 100,
  parameter int unsigned     FILTER_CYC   = 5
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic safety_off_request_a_i,
  input wire logic safety_off_request_b_i,
  input wire logic servo_on_i,
  input wire logic alarm_clear_i,
  input wire logic gate_enable_a_o,
  input wire logic gate_enable_b_o,
  input wire logic servo_ready_o,
  input wire logic hardwired_safe_off_state_o,
  input wire logic base_block_state_o,
  input wire logic safety_input_timing_alarm_o
);
  wire logic  ra = safety_off_request_a_i;
  wire logic  rb = safety_off_request_b_i;
  logic [15:0] lo_a_q, lo_b_q, mm_q, ok_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  function automatic logic [15:0] inc(input logic [15:0] x);
    return x + 16'(x != 16'hffff);
  endfunction
  // Run lengths saturate so a long quiet span never wraps back to zero.
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      lo_a_q <= 16'h0;
      lo_b_q <= 16'h0;
      mm_q <= 16'h0;
      ok_q <= 16'h0;
    end
    else
    begin
      lo_a_q <= ra ? 16'h0 : inc(lo_a_q);
      lo_b_q <= rb ? 16'h0 : inc(lo_b_q);
      mm_q <= (ra == rb) ? 16'h0 : inc(mm_q);
      ok_q <= (ra && rb && !servo_on_i) ? inc(ok_q) : 16'h0;
    end
  gates_run_a: assert property (
    gate_enable_a_o || gate_enable_b_o |->
      !servo_ready_o && !hardwired_safe_off_state_o)
    else $error("gate on outside run");
  ready_bb_a: assert property (
    servo_ready_o == base_block_state_o) else $error("ready not bb");
  chan_a_off_a: assert property (
    lo_a_q >= FILTER_CYC + 8 |-> !gate_enable_a_o && !gate_enable_b_o
      && hardwired_safe_off_state_o) else $error("a off ignored");
  chan_b_off_a: assert property (
    lo_b_q >= FILTER_CYC + 8 |-> !gate_enable_a_o && !gate_enable_b_o
      && hardwired_safe_off_state_o) else $error("b off ignored");
  alarm_set_a: assert property (
    mm_q >= MISMATCH_CYC + FILTER_CYC + 8 |-> safety_input_timing_alarm_o)
    else $error("no timing alarm");
  alarm_hold_a: assert property (
    safety_input_timing_alarm_o && !alarm_clear_i && !$past(alarm_clear_i)
      && !$past(alarm_clear_i, 2) && !$past(alarm_clear_i, 3)
      |=> safety_input_timing_alarm_o) else $error("alarm dropped");
  both_on_a: assert property (
    ok_q >= 12 |-> base_block_state_o) else $error("no base block");
  run_entry_a: assert property (
    $rose(gate_enable_a_o) |-> $past(base_block_state_o))
    else $error("run not from bb");
endmodule
bind safe_torque_off sto_checker #(
  .MISMATCH_CYC(MISMATCH_CYC),
  .FILTER_CYC(FILTER_CYC)
) u_chk (.*);
`default_nettype wire

// File: sim/sto_partner.sv
`default_nettype none
// Relay chain; a large lag_i models a stuck second contact.
module sto_partner (
  input  wire logic        clk_i,
  input  wire logic        close_i,
  input  wire logic        test_pulse_i,
  input  wire logic [15:0] lag_i,
  output logic             chan_a_o,
  output logic             chan_b_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] cnt = 16'h0;
  initial
  begin
    chan_a_o = 1'b0;
    chan_b_o = 1'b0;
  end
  // Open contacts carry no current, so the drive must read OFF.
  always @(posedge clk_i)
  begin
    chan_a_o <= close_i && !test_pulse_i;
    if (chan_b_o == close_i)
      cnt <= 16'h0;
    else if (cnt >= lag_i)
      chan_b_o <= close_i;
    else
      cnt <= cnt + 16'h1;
  end
endmodule
`default_nettype wire

// File: sim/dual_channel_safe_torque_off_tb.sv
`default_nettype none
module dual_channel_safe_torque_off_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        close = 1'b0;
  logic        pulse = 1'b0;
  logic        son = 1'b0;
  logic        clr = 1'b0;
  logic [15:0] lag = 16'h0;
  logic        ra, rb, ga, gb, rdy, soff, bb, alm;
  int          n_mismatch = 0;
  int          check_count = 0;
  always #10 clk_i = ~clk_i;
  sto_partner u_relay (.clk_i, .close_i(close), .test_pulse_i(pulse),
    .lag_i(lag), .chan_a_o(ra), .chan_b_o(rb));
  // Short counts keep the run brief; expectations follow from them.
  safe_torque_off #(.MISMATCH_CYC(100), .FILTER_CYC(5)) dut (.clk_i,
    .nrst_i, .safety_off_request_a_i(ra), .safety_off_request_b_i(rb),
    .servo_on_i(son), .alarm_clear_i(clr), .gate_enable_a_o(ga),
    .gate_enable_b_o(gb), .servo_ready_o(rdy),
    .hardwired_safe_off_state_o(soff), .base_block_state_o(bb),
    .safety_input_timing_alarm_o(alm));
  // Status order: gate a, gate b, ready, safe-off, base-block, alarm.
  task automatic chk(input logic [5:0] exp);
    check_count++;
    if ({ga, gb, rdy, soff, bb, alm} !== exp)
    begin
      n_mismatch++;
      $display("Error t=%0t got %h exp %h", $time,
        {ga, gb, rdy, soff, bb, alm}, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic test_done;
    $display("Mismatches %0d of %0d checks", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // A pulse at the glitch limit must not disturb a running drive;
  // one cycle longer is a real OFF request and stops it. Servo-on was up,
  // so the drive re-arms only after servo-on is dropped and raised again.
  task automatic t_glitch;
    pulse = 1'b1;
    wt(4);
    pulse = 1'b0;
    wt(20);
    chk(6'h30);
    pulse = 1'b1;
    wt(5);
    pulse = 1'b0;
    wt(20);
    chk(6'h04);
    son = 1'b0;
    wt(10);
    chk(6'h0a);
    son = 1'b1;
    wt(10);
    chk(6'h30);
  endtask
  // Channel B lags far beyond the mismatch limit while servo-on stays up.
  task automatic t_one_chan;
    lag = 16'd300;
    close = 1'b0;
    wt(15);
    chk(6'h04);
    wt(110);
    chk(6'h05);
    wt(200);
    lag = 16'h0;
    close = 1'b1;
    wt(15);
    chk(6'h05);
    son = 1'b0;
    wt(10);
    chk(6'h0b);
    son = 1'b1;
    wt(10);
    chk(6'h31);
    clr = 1'b1;
    wt(6);
    clr = 1'b0;
    wt(4);
    chk(6'h30);
  endtask
  // Orderly stop: servo-on drops before both contacts open.
  task automatic t_normal_off;
    son = 1'b0;
    wt(10);
    chk(6'h0a);
    close = 1'b0;
    wt(14);
    chk(6'h04);
  endtask
  initial
  begin
    wt(1);
    chk(6'h04);
    wt(19);
    nrst_i = 1'b1;
    close = 1'b1;
    // Base-block is held long enough for the checker to see it settle.
    wt(16);
    chk(6'h0a);
    son = 1'b1;
    wt(8);
    chk(6'h30);
    t_glitch();
    t_one_chan();
    t_normal_off();
    test_done();
  end
  // The sequence needs about 500 cycles; four times that means a hang.
  initial
  begin
    wt(2000);
    n_mismatch++;
    test_done();
  end
endmodule
`default_nettype wire
